// file: verilog/status_pin_routing.sv
/*
 * status pin routing: clip configuration, fault pin and two general-purpose pins.
 * assumes a register port on clk_sys, status inputs from logic on clk_sys, and
 * pins whose inputs arrive asynchronously.
 */
// How it works
// R1 - clip detection runs only while enable set
// R2 - threshold field picks 2, 5, 10, 1 percent
// R3 - upper pair clipping drives group two
// R4 - upper pair clipping drives group one
// R5 - lower pair clipping drives group two
// R6 - lower pair clipping drives group one
// R7 - fault pin open drain fault or warning
// R8 - fault pin push-pull clip group one/two
// R9 - gp pin hi-z, warning or fault open drain
// R10 - gp pin push-pull clip group one/two
// R11 - gp pin push-pull switching frequency out
// R12 - gp pin constant high or low
// R13 - gp pin sync input followed by device
// R14 - gp pin active-low mute input
// R15 - warning is any enabled source set
// R16 - unlisted codes leave pin inactive
// R17 - groups inactive while detection disabled
`timescale 1ns/1ps
`include "status_pin_cfg.svh"

module status_pin_routing
	import status_pin_pkg::*;
#(
	parameter int WARN_W = 8,
	parameter int GP_PINS = 2
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic chan_one_clipping,
	input wire logic chan_two_clipping,
	input wire logic chan_three_clipping,
	input wire logic chan_four_clipping,
	input wire logic fault_active,
	input wire logic [WARN_W-1:0] warn_sources,
	input wire logic [WARN_W-1:0] warn_enables,
	input wire logic sw_freq_level,
	output logic fault_pin_out,
	output logic fault_pin_oe_n,
	input wire logic [GP_PINS-1:0] gp_pin_in,
	output logic [GP_PINS-1:0] gp_pin_out,
	output logic [GP_PINS-1:0] gp_pin_oe_n,
	output logic clip_detect_enable,
	output logic [1:0] clip_threshold_select,
	output logic clip_group_one,
	output logic clip_group_two,
	output logic warn_active,
	output logic mute_request,
	output logic ext_sync_select,
	output logic ext_sync_level
);

	// ****************************************
	// declarations
	// ****************************************
	logic [7:0] clip_cfg_reg, clip_cfg_next; // clip configuration
	logic [7:0] fault_cfg_reg, fault_cfg_next; // fault pin function
	logic [7:0] gp_cfg_reg, gp_cfg_next; // both gp pin functions
	logic [7:0] rdata_reg, rdata_next; // read data
	logic grp_one_reg, grp_one_next; // clip group one
	logic grp_two_reg, grp_two_next; // clip group two
	logic warn_reg, warn_next; // warning signal
	logic fpin_out_reg, fpin_out_next; // fault pin level
	logic fpin_oe_n_reg, fpin_oe_n_next; // fault pin enable
	logic [GP_PINS-1:0] gp_out_reg, gp_out_next; // gp pin levels
	logic [GP_PINS-1:0] gp_oe_n_reg, gp_oe_n_next; // gp pin enables
	logic [GP_PINS-1:0] gp_meta_reg; // first sync stage
	logic [GP_PINS-1:0] gp_sync_reg; // second sync stage
	logic mute_reg, mute_next; // mute request
	logic sync_sel_reg, sync_sel_next; // external sync chosen
	logic sync_lvl_reg, sync_lvl_next; // followed sync level
	logic [GP_PINS-1:0] drv_out; // driver decoded level
	logic [GP_PINS-1:0] drv_oe_n; // driver decoded enable
	logic [GP_PINS-1:0] mute_in_n; // per-pin mute, active low
	logic [GP_PINS-1:0] is_sync_in; // per-pin sync in selected
	logic [GP_PINS-1:0] sync_in_lvl; // per-pin sync level
	pin_status_if st ();

	// ****************************************
	// helper functions
	// ****************************************
	// register read decode; unmapped addresses read as zero
	function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] clip,
		input logic [7:0] fault, input logic [7:0] gp);
		logic [7:0] value;
		value = `UNMAPPED_READ;
		case (addr)
			`CLIP_CFG_ADDR: value = clip;
			`FAULT_CFG_ADDR: value = fault;
			`GP_CFG_ADDR: value = gp;
			default: value = `UNMAPPED_READ;
		endcase
		return value;
	endfunction

	// function field of one gp pin
	function automatic logic [3:0] gp_func(input logic [7:0] cfg, input int idx);
		return cfg[idx*`GP_FUNC_W +: `GP_FUNC_W];
	endfunction

	// ****************************************
	// register file
	// ****************************************
	// writes land at the next edge; reads answer one edge after the strobe
	always_comb begin
		clip_cfg_next = clip_cfg_reg;
		fault_cfg_next = fault_cfg_reg;
		gp_cfg_next = gp_cfg_reg;
		rdata_next = rdata_reg;
		if (reg_write) begin
			case (reg_addr)
				`CLIP_CFG_ADDR: clip_cfg_next = reg_wdata;
				`FAULT_CFG_ADDR: fault_cfg_next = reg_wdata;
				`GP_CFG_ADDR: gp_cfg_next = reg_wdata;
				default: clip_cfg_next = clip_cfg_reg; // unmapped write ignored
			endcase
		end
		if (reg_read) begin
			rdata_next = read_mux(reg_addr, clip_cfg_reg, fault_cfg_reg, gp_cfg_reg);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			clip_cfg_reg <= `CLIP_CFG_RESET;
			fault_cfg_reg <= `FAULT_CFG_RESET;
			gp_cfg_reg <= `GP_CFG_RESET;
			rdata_reg <= `UNMAPPED_READ;
		end else begin
			clip_cfg_reg <= clip_cfg_next;
			fault_cfg_reg <= fault_cfg_next;
			gp_cfg_reg <= gp_cfg_next;
			rdata_reg <= rdata_next;
		end
	end

	// ****************************************
	// clip groups and warning
	// ****************************************
	// both groups forced off while detection is disabled
	always_comb begin
		grp_one_next = 1'b0;
		grp_two_next = 1'b0;
		if (clip_cfg_reg[`CLIP_EN_BIT]) begin // [R1] [R17]
			grp_one_next = (clip_cfg_reg[`LOWER_TO_ONE_BIT]
				&& (chan_one_clipping || chan_two_clipping)) // [R6]
				|| (clip_cfg_reg[`UPPER_TO_ONE_BIT]
				&& (chan_three_clipping || chan_four_clipping)); // [R4]
			grp_two_next = (clip_cfg_reg[`LOWER_TO_TWO_BIT]
				&& (chan_one_clipping || chan_two_clipping)) // [R5]
				|| (clip_cfg_reg[`UPPER_TO_TWO_BIT]
				&& (chan_three_clipping || chan_four_clipping)); // [R3]
		end
		warn_next = |(warn_sources & warn_enables); // [R15]
		st.grp_one = grp_one_next;
		st.grp_two = grp_two_next;
		st.warn_out_n = ~warn_next;
		st.fault_out_n = ~fault_active;
		st.sync_out = sw_freq_level;
	end

	// ****************************************
	// fault pin
	// ****************************************
	// open drain modes pull low on the active signal, else release
	always_comb begin
		fpin_out_next = 1'b0;
		fpin_oe_n_next = 1'b1;
		case (fault_cfg_reg[`FAULT_FUNC_HI:`FAULT_FUNC_LO])
			FP_FAULT: fpin_oe_n_next = ~fault_active; // [R7]
			FP_WARN: fpin_oe_n_next = ~warn_next; // [R7]
			FP_GRP_ONE: begin
				fpin_out_next = grp_one_next; // [R8]
				fpin_oe_n_next = 1'b0;
			end
			FP_GRP_TWO: begin
				fpin_out_next = grp_two_next; // [R8]
				fpin_oe_n_next = 1'b0;
			end
			default: fpin_oe_n_next = 1'b1; // [R16]
		endcase
	end

	// ****************************************
	// general-purpose pins
	// ****************************************
	// one decoder per pin, each reading its own function field
	for (genvar i = 0; i < GP_PINS; i++) begin : g_pin
		gp_pin_driver u_drv (
			.st(st),
			.func(gp_func(gp_cfg_reg, i)),
			.pin_out(drv_out[i]),
			.pin_oe_n(drv_oe_n[i])
		);
		assign is_sync_in[i] = gp_func(gp_cfg_reg, i) == GP_SYNC_IN;
		assign mute_in_n[i] = !(gp_func(gp_cfg_reg, i) == GP_MUTE) || gp_sync_reg[i];
		assign sync_in_lvl[i] = is_sync_in[i] && gp_sync_reg[i];
	end

	// mute while any mute-configured pin is held low; lowest pin wins sync
	always_comb begin
		gp_out_next = drv_out;
		gp_oe_n_next = drv_oe_n;
		mute_next = ~&mute_in_n; // [R14]
		sync_sel_next = |is_sync_in; // [R13]
		sync_lvl_next = 1'b0;
		for (int k = GP_PINS - 1; k >= 0; k--) begin
			if (is_sync_in[k]) begin
				sync_lvl_next = sync_in_lvl[k]; // [R13]
			end
		end
	end

	// ****************************************
	// status and pin registers
	// ****************************************
	// pin inputs pass two flops before any logic reads them
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			grp_one_reg <= 1'b0;
			grp_two_reg <= 1'b0;
			warn_reg <= 1'b0;
			fpin_out_reg <= 1'b0;
			fpin_oe_n_reg <= 1'b1;
			gp_out_reg <= '0;
			gp_oe_n_reg <= '1;
			gp_meta_reg <= '1;
			gp_sync_reg <= '1;
			mute_reg <= 1'b0;
			sync_sel_reg <= 1'b0;
			sync_lvl_reg <= 1'b0;
		end else begin
			grp_one_reg <= grp_one_next;
			grp_two_reg <= grp_two_next;
			warn_reg <= warn_next;
			fpin_out_reg <= fpin_out_next;
			fpin_oe_n_reg <= fpin_oe_n_next;
			gp_out_reg <= gp_out_next;
			gp_oe_n_reg <= gp_oe_n_next;
			gp_meta_reg <= gp_pin_in;
			gp_sync_reg <= gp_meta_reg;
			mute_reg <= mute_next;
			sync_sel_reg <= sync_sel_next;
			sync_lvl_reg <= sync_lvl_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign reg_rdata = rdata_reg;
	assign clip_detect_enable = clip_cfg_reg[`CLIP_EN_BIT]; // [R1]
	assign clip_threshold_select = clip_cfg_reg[`CLIP_LVL_HI:`CLIP_LVL_LO]; // [R2]
	assign clip_group_one = grp_one_reg;
	assign clip_group_two = grp_two_reg;
	assign warn_active = warn_reg;
	assign fault_pin_out = fpin_out_reg;
	assign fault_pin_oe_n = fpin_oe_n_reg;
	assign gp_pin_out = gp_out_reg;
	assign gp_pin_oe_n = gp_oe_n_reg;
	assign mute_request = mute_reg;
	assign ext_sync_select = sync_sel_reg;
	assign ext_sync_level = sync_lvl_reg;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_clip_write(logic [7:0] v);
		reg_write && reg_addr == `CLIP_CFG_ADDR && reg_wdata == v;
	endsequence
	property p_clip_off;
		!clip_detect_enable |=> !clip_group_one && !clip_group_two;
	endproperty
	a_clip_off: assert property (p_clip_off) else $error("clip group active while disabled"); // [R1]
	property p_level;
		s_clip_write(8'h30) |=> clip_threshold_select == THD_1PCT ##1 !clip_detect_enable;
	endproperty
	a_level: assert property (p_level) else $error("threshold field not taken"); // [R2]
	property p_upper_two;
		clip_detect_enable && clip_cfg_reg[`UPPER_TO_TWO_BIT] && chan_four_clipping
			|=> clip_group_two;
	endproperty
	a_upper_two: assert property (p_upper_two) else $error("group two missed upper pair"); // [R3]
	property p_upper_one;
		clip_detect_enable && clip_cfg_reg[`UPPER_TO_ONE_BIT] && chan_three_clipping
			|=> clip_group_one;
	endproperty
	a_upper_one: assert property (p_upper_one) else $error("group one missed upper pair"); // [R4]
	property p_lower_masked;
		!clip_cfg_reg[`LOWER_TO_TWO_BIT] && !clip_cfg_reg[`UPPER_TO_TWO_BIT] |=> !clip_group_two;
	endproperty
	a_lower_masked: assert property (p_lower_masked) else $error("group two without mapping"); // [R5]
	property p_lower_one;
		clip_detect_enable && clip_cfg_reg[`LOWER_TO_ONE_BIT] && chan_two_clipping
			|=> clip_group_one;
	endproperty
	a_lower_one: assert property (p_lower_one) else $error("group one missed lower pair"); // [R6]
	// the enable must follow the fault level of the previous cycle
	property p_fault_od;
		fault_cfg_reg[3:0] == FP_FAULT |=> fault_pin_oe_n == !$past(fault_active) && !fault_pin_out;
	endproperty
	a_fault_od: assert property (p_fault_od) else $error("fault pin not open drain fault"); // [R7]
	property p_fault_clip;
		fault_cfg_reg[3:0] == FP_GRP_TWO |=> !fault_pin_oe_n && fault_pin_out == clip_group_two;
	endproperty
	a_fault_clip: assert property (p_fault_clip) else $error("fault pin not group two"); // [R8]
	property p_gp_const;
		gp_cfg_reg[3:0] == GP_HIGH |=> !gp_pin_oe_n[0] && gp_pin_out[0];
	endproperty
	a_gp_const: assert property (p_gp_const) else $error("gp pin one not held high"); // [R12]
	sequence s_mute_held;
		(gp_cfg_reg[7:4] == GP_MUTE && !gp_pin_in[1]) [*4];
	endsequence
	property p_mute;
		s_mute_held |=> mute_request;
	endproperty
	a_mute: assert property (p_mute) else $error("mute not requested"); // [R14]
	property p_warn;
		|(warn_sources & warn_enables) |=> warn_active;
	endproperty
	a_warn: assert property (p_warn) else $error("warning not raised"); // [R15]
	property p_unlisted;
		gp_cfg_reg[3:0] > GP_MUTE |=> gp_pin_oe_n[0];
	endproperty
	a_unlisted: assert property (p_unlisted) else $error("unlisted code drives pin"); // [R16]
endmodule

// file: verilog/status_pin_cfg.svh
/*
 * register addresses, field positions and reset values of the status pin routing block.
 * assumes it is included by bare name from the routing file; the pin driver file does not include it.
 */
`ifndef STATUS_PIN_CFG_SVH
`define STATUS_PIN_CFG_SVH

// ****************************************
// register addresses
// ****************************************
`define CLIP_CFG_ADDR 8'h21
`define FAULT_CFG_ADDR 8'h22
`define GP_CFG_ADDR 8'h23

// ****************************************
// reset values
// ****************************************
`define CLIP_CFG_RESET 8'h00
`define FAULT_CFG_RESET 8'h00
`define GP_CFG_RESET 8'h00
`define UNMAPPED_READ 8'h00

// ****************************************
// clip configuration field positions
// ****************************************
`define CLIP_EN_BIT 6
`define CLIP_LVL_HI 5
`define CLIP_LVL_LO 4
`define UPPER_TO_TWO_BIT 3
`define UPPER_TO_ONE_BIT 2
`define LOWER_TO_TWO_BIT 1
`define LOWER_TO_ONE_BIT 0

// ****************************************
// pin function field positions
// ****************************************
`define FAULT_FUNC_HI 3
`define FAULT_FUNC_LO 0
`define GP_FUNC_W 4

`endif

// file: verilog/status_pin_pkg.sv
/*
 * types shared by the status pin routing block: pin function codes and clip levels.
 * assumes nothing of its surroundings.
 */
package status_pin_pkg;

	// ****************************************
	// pin function codes
	// ****************************************
	typedef enum logic [3:0] {
		FP_FAULT = 4'h0,
		FP_WARN = 4'h1,
		FP_GRP_ONE = 4'h2,
		FP_GRP_TWO = 4'h3
	} fault_func_e;

	typedef enum logic [3:0] {
		GP_HIZ = 4'h0,
		GP_WARN = 4'h1,
		GP_FAULT = 4'h2,
		GP_GRP_ONE = 4'h3,
		GP_GRP_TWO = 4'h4,
		GP_SYNC_OUT = 4'h5,
		GP_HIGH = 4'h6,
		GP_LOW = 4'h7,
		GP_SYNC_IN = 4'h8,
		GP_MUTE = 4'h9
	} gp_func_e;

	// clip threshold selection
	typedef enum logic [1:0] {
		THD_2PCT = 2'h0,
		THD_5PCT = 2'h1,
		THD_10PCT = 2'h2,
		THD_1PCT = 2'h3
	} clip_level_e;

endpackage

// file: verilog/pin_status_if.sv
/*
 * status signals that the routing block hands to each pin driver.
 * assumes all signals are the next-cycle values, on clk_sys.
 */
`timescale 1ns/1ps

interface pin_status_if;
	logic warn_out_n; // warning, active low
	logic fault_out_n; // fault, active low
	logic grp_one; // clip group one
	logic grp_two; // clip group two
	logic sync_out; // switching frequency level
	modport source (output warn_out_n, fault_out_n, grp_one, grp_two, sync_out);
	modport sink (input warn_out_n, fault_out_n, grp_one, grp_two, sync_out);
endinterface

// file: verilog/gp_pin_driver.sv
/*
 * combinational drive decode of one general-purpose pin from its function code.
 * assumes the parent registers pin_out and pin_oe_n before they reach the pad.
 */
`timescale 1ns/1ps

module gp_pin_driver
	import status_pin_pkg::*;
(
	pin_status_if.sink st,
	input wire logic [3:0] func,
	output logic pin_out,
	output logic pin_oe_n
);

	// ****************************************
	// drive decode
	// ****************************************
	// oe_n low means the pad is driven; open drain releases by raising oe_n
	always_comb begin
		pin_out = 1'b0;
		pin_oe_n = 1'b1;
		case (func)
			GP_HIZ: begin
				pin_oe_n = 1'b1; // [R9]
			end
			GP_WARN: begin
				pin_oe_n = st.warn_out_n; // [R9]
			end
			GP_FAULT: begin
				pin_oe_n = st.fault_out_n; // [R9]
			end
			GP_GRP_ONE: begin
				pin_out = st.grp_one; // [R10]
				pin_oe_n = 1'b0;
			end
			GP_GRP_TWO: begin
				pin_out = st.grp_two; // [R10]
				pin_oe_n = 1'b0;
			end
			GP_SYNC_OUT: begin
				pin_out = st.sync_out; // [R11]
				pin_oe_n = 1'b0;
			end
			GP_HIGH: begin
				pin_out = 1'b1; // [R12]
				pin_oe_n = 1'b0;
			end
			GP_LOW: begin
				pin_out = 1'b0; // [R12]
				pin_oe_n = 1'b0;
			end
			GP_SYNC_IN, GP_MUTE: begin
				pin_oe_n = 1'b1; // [R13] [R14]
			end
			default: begin
				pin_oe_n = 1'b1; // [R16]
			end
		endcase
	end

endmodule

// file: tb/pin_side_model.sv
/*
 * board side of the status pins: a pull-up on every pad and an external party
 * that may drive the general-purpose pads, as sync clock master or mute source.
 * assumes pad enables are active low, as the routing block drives them.
 */
`timescale 1ns/1ps

module pin_side_model #(
	parameter int GP_PINS = 2
) (
	input wire logic [GP_PINS-1:0] gp_out, // device pad levels
	input wire logic [GP_PINS-1:0] gp_oe_n, // device pad enables, low = driven
	input wire logic [GP_PINS-1:0] ext_en, // external party drives the pad
	input wire logic [GP_PINS-1:0] ext_level, // level the external party drives
	input wire logic fault_out,
	input wire logic fault_oe_n,
	output logic [GP_PINS-1:0] gp_pad, // resolved pad levels
	output logic fault_pad
);
	// ****************************************
	// pad resolution
	// ****************************************
	// device, external party or pull-up; two drivers at once give an unknown
	always_comb begin
		for (int i = 0; i < GP_PINS; i++) begin
			if (!gp_oe_n[i] && ext_en[i]) begin
				gp_pad[i] = 1'bx; // contention
			end else if (!gp_oe_n[i]) begin
				gp_pad[i] = gp_out[i];
			end else if (ext_en[i]) begin
				gp_pad[i] = ext_level[i]; // master clock or mute level held
			end else begin
				gp_pad[i] = 1'b1; // released pad rests at the pull-up
			end
		end
	end

	// fault pad carries only a pull-up
	assign fault_pad = fault_oe_n ? 1'b1 : fault_out;
endmodule

// file: tb/status_pin_routing_tb.sv
/*
 * self-checking bench of the status pin routing block.
 * assumes the block on a 200 MHz clock and the pin side model on its pads.
 */
`timescale 1ns/1ps

module status_pin_routing_tb;
	import status_pin_pkg::*;

	// ****************************************
	// signals
	// ****************************************
	logic clk_sys, rst_n, reg_write, reg_read, fault_active, sw_freq_level;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, warn_sources, warn_enables;
	logic [3:0] chans; // channel clipping, bit 0 is channel one
	logic fault_pin_out, fault_pin_oe_n, clip_detect_enable, clip_group_one, clip_group_two;
	logic warn_active, mute_request, ext_sync_select, ext_sync_level, fault_pad;
	logic [1:0] gp_pin_in, gp_pin_out, gp_pin_oe_n, clip_threshold_select, ext_en, ext_level;
	int n_errors, compares;

	status_pin_routing i_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.chan_one_clipping(chans[0]), .chan_two_clipping(chans[1]),
		.chan_three_clipping(chans[2]), .chan_four_clipping(chans[3]),
		.fault_active(fault_active), .warn_sources(warn_sources), .warn_enables(warn_enables),
		.sw_freq_level(sw_freq_level), .fault_pin_out(fault_pin_out),
		.fault_pin_oe_n(fault_pin_oe_n), .gp_pin_in(gp_pin_in), .gp_pin_out(gp_pin_out),
		.gp_pin_oe_n(gp_pin_oe_n), .clip_detect_enable(clip_detect_enable),
		.clip_threshold_select(clip_threshold_select), .clip_group_one(clip_group_one),
		.clip_group_two(clip_group_two), .warn_active(warn_active),
		.mute_request(mute_request), .ext_sync_select(ext_sync_select),
		.ext_sync_level(ext_sync_level)
	);

	pin_side_model i_pins (
		.gp_out(gp_pin_out), .gp_oe_n(gp_pin_oe_n), .ext_en(ext_en), .ext_level(ext_level),
		.fault_out(fault_pin_out), .fault_oe_n(fault_pin_oe_n), .gp_pad(gp_pin_in),
		.fault_pad(fault_pad)
	);

	// ****************************************
	// helpers
	// ****************************************
	// clock: 5 ns period
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// register write, taken at the second edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask

	// register read, data stands after the edge that takes it
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata, exp, what);
	endtask

	// let a config change reach the pins
	task automatic settle();
		repeat (2) @(posedge clk_sys);
		#1;
	endtask

	task automatic set_status(input logic [3:0] ch, input logic f, input logic [7:0] en,
			input logic sw);
		@(posedge clk_sys);
		chans <= ch;
		fault_active <= f;
		warn_sources <= 8'h05;
		warn_enables <= en;
		sw_freq_level <= sw;
	endtask

	// expected {enable_n, pad} of a gp code; one = fault, group one, sync high
	function automatic logic [1:0] pin_exp(input logic [3:0] c, input logic one);
		case (c)
			4'h1: pin_exp = one ? 2'b11 : 2'b00; // warning pulls low
			4'h2: pin_exp = one ? 2'b00 : 2'b11; // fault pulls low
			4'h3: pin_exp = {1'b0, one};
			4'h4: pin_exp = {1'b0, !one};
			4'h5: pin_exp = {1'b0, one};
			4'h6: pin_exp = 2'b01;
			4'h7: pin_exp = 2'b00;
			default: pin_exp = 2'b11; // released, pull-up shows
		endcase
	endfunction

	// ****************************************
	// scenarios
	// ****************************************
	task automatic reset_values();
		#1;
		chk({fault_pin_oe_n, fault_pad, gp_pin_oe_n}, 4'b1111, "pins at reset"); // released
		wr(8'h30, 8'hFF);
		rd(8'h30, 8'h00, "unmapped read");
		rd(8'h21, 8'h00, "clip cfg reset"); // detection off after reset
		rd(8'h22, 8'h00, "fault cfg reset"); // fault open drain after reset
		rd(8'h23, 8'h00, "gp cfg reset"); // both gp pins hi-z after reset
	endtask

	task automatic clip_routing();
		for (int b = 0; b < 4; b++) begin
			for (int ch = 0; ch < 4; ch++) begin
				wr(8'h21, 8'h40 | (8'h01 << b));
				set_status(4'h1 << ch, 1'b0, 8'h00, 1'b0);
				settle();
				chk(clip_group_one, (b == 0 && ch < 2) || (b == 2 && ch > 1), "g1"); // map
				chk(clip_group_two, (b == 1 && ch < 2) || (b == 3 && ch > 1), "g2"); // map
			end
		end
		wr(8'h21, 8'h0F);
		set_status(4'hF, 1'b0, 8'h00, 1'b0);
		settle();
		chk({clip_detect_enable, clip_group_one, clip_group_two}, 3'b000, "off"); // off
	endtask

	task automatic clip_levels();
		for (int l = 0; l < 4; l++) begin
			wr(8'h21, {2'b01, l[1:0], 4'h0});
			settle();
			chk({clip_detect_enable, clip_threshold_select}, {1'b1, l[1:0]}, "level");
			rd(8'h21, {2'b01, l[1:0], 4'h0}, "clip cfg"); // stored threshold
		end
		// one percent threshold with detection switched off
		wr(8'h21, 8'h30);
		settle();
		chk({clip_detect_enable, clip_threshold_select}, 3'b011, "level off");
		wr(8'h22, 8'hA3);
		wr(8'h21, 8'hC5);
		rd(8'h21, 8'hC5, "clip reserved"); // reserved bit kept
		rd(8'h22, 8'hA3, "fault reserved"); // reserved nibble kept
	endtask

	task automatic pin_codes();
		logic one;
		logic [3:0] fc;
		for (int p = 0; p < 2; p++) begin
			one = (p == 0);
			wr(8'h21, 8'h49);
			set_status(one ? 4'b0001 : 4'b0100, one, one ? 8'h0A : 8'h04, one);
			for (int c = 0; c < 16; c++) begin
				wr(8'h23, {c[3:0], c[3:0]});
				wr(8'h22, {4'h0, c[3:0]});
				settle();
				fc = (c == 0) ? 4'h2 : (c == 1) ? 4'h1 : (c < 4) ? c[3:0] + 4'h1 : 4'h0;
				chk({gp_pin_oe_n[0], gp_pin_in[0]}, pin_exp(c[3:0], one), "gp one");
				chk({gp_pin_oe_n[1], gp_pin_in[1]}, pin_exp(c[3:0], one), "gp two");
				chk({fault_pin_oe_n, fault_pad}, pin_exp(fc, one), "fault pin");
				chk({ext_sync_select, mute_request}, {c == 8, 1'b0}, "inputs idle"); // sync
			end
			chk({warn_active, clip_group_one, clip_group_two}, {!one, one, !one}, "status");
		end
	endtask

	task automatic pin_inputs();
		wr(8'h23, 8'h98);
		for (int v = 0; v < 4; v++) begin
			@(posedge clk_sys);
			ext_en <= 2'b11;
			ext_level <= v[1:0];
			repeat (4) @(posedge clk_sys);
			#1;
			chk(gp_pin_oe_n, 2'b11, "inputs released"); // input pins
			chk({ext_sync_select, ext_sync_level}, {1'b1, v[0]}, "sync in"); // followed
			chk(mute_request, !v[1], "mute"); // low mutes
		end
		@(posedge clk_sys);
		ext_en <= 2'b00;
	endtask

	// ****************************************
	// verdict and run
	// ****************************************
	task automatic summarize();
		if (n_errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// watchdog: the run needs about 360 cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		summarize();
	end

	initial begin
		n_errors = 0;
		compares = 0;
		rst_n = 1'b0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		chans = 4'h0;
		fault_active = 1'b0;
		warn_sources = 8'h00;
		warn_enables = 8'h00;
		sw_freq_level = 1'b0;
		ext_en = 2'b00;
		ext_level = 2'b00;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		reset_values();
		clip_routing();
		clip_levels();
		pin_codes();
		pin_inputs();
		summarize();
	end
endmodule
